/* sat_pkg.sv */
// shared constants for the smbus target address and timeout block
package sat_pkg;
    // clock and bus timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TIMEOUT_MIN_MS = 25;
    localparam int unsigned TIMEOUT_MAX_MS = 35;
    localparam int unsigned SEXT_MAX_MS    = 25;
    localparam int unsigned MEXT_MAX_MS    = 10;
    localparam int unsigned HIGH_MAX_US    = 50;
    localparam int unsigned TIMEOUT_CYC    =
        TIMEOUT_MIN_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned SEXT_CYC       =
        SEXT_MAX_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned HIGH_MAX_CYC   =
        (HIGH_MAX_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 22;
    // clock stretch applied after every byte the target acknowledges
    localparam int unsigned STRETCH_CYC    = 8;
    // strap settle time before the address is latched
    localparam int unsigned SETTLE_CYC     = 16;
    localparam int unsigned SETTLE_W       = 5;
    // address decode
    localparam logic [6:0] ADDR_BASE_LO    = 7'h40;
    localparam logic [6:0] ADDR_BASE_MID   = 7'h08;
    localparam int unsigned IDX_MID        = 8;
    localparam int unsigned IDX_HI         = 16;
    localparam logic [6:0] ARA_ADDR        = 7'h0C;
    // command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'hD8;
    localparam logic [7:0] ALERT_MASK_RST   = 8'h00;
    localparam int unsigned FAULT_W         = 8;
    // ternary strap digit codes
    typedef enum logic [1:0] {
        TRI_FLOAT,
        TRI_LOW,
        TRI_HIGH
    } sat_tri_type;
endpackage

/* sat_addr_if.sv */
// carrier for the latched strap address
interface sat_addr_if;
    logic [6:0] addr;
    logic       valid;
    modport source (output addr, output valid);
    modport sink   (input addr, input valid);
endinterface

/* sat_strap.sv */
// strap sampling and tri-level address decode
module sat_strap (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [1:0] addr_strap_bit0_i,
    input  wire logic [1:0] addr_strap_bit1_i,
    input  wire logic [1:0] addr_strap_bit2_i,
    sat_addr_if.source      addr_if
);
    logic [sat_pkg::SETTLE_W-1:0] settle_q;
    logic [6:0]                   addr_q;
    logic                         valid_q;

    // strap pair {high sense, low sense}; neither means floating
    function automatic sat_pkg::sat_tri_type tri_level(input logic [1:0] s);
        if (s[1]) begin
            return sat_pkg::TRI_HIGH; // RULE_01
        end else if (s[0]) begin
            return sat_pkg::TRI_LOW;
        end
        return sat_pkg::TRI_FLOAT;
    endfunction

    // 27 combinations onto three address ranges
    function automatic logic [6:0] decode(input logic [4:0] idx);
        if (idx < 5'(sat_pkg::IDX_MID)) begin
            return sat_pkg::ADDR_BASE_LO + 7'(idx); // RULE_02
        end else if (idx < 5'(sat_pkg::IDX_HI)) begin
            return sat_pkg::ADDR_BASE_MID + 7'(idx);
        end
        return sat_pkg::ADDR_BASE_LO + 7'(idx);
    endfunction

    logic [4:0] idx;
    assign idx = 5'(tri_level(addr_strap_bit2_i)) * 5'h09
               + 5'(tri_level(addr_strap_bit1_i)) * 5'h03
               + 5'(tri_level(addr_strap_bit0_i));

    // wait for straps to settle, then latch once
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            settle_q <= '0;
            valid_q  <= 1'b0;
            addr_q   <= '0;
        end else if (!valid_q) begin
            if (settle_q == sat_pkg::SETTLE_W'(sat_pkg::SETTLE_CYC)) begin
                addr_q  <= decode(idx); // RULE_14
                valid_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 1'b1;
            end
        end
    end

    assign addr_if.addr  = addr_q;
    assign addr_if.valid = valid_q;

    latch_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_14
        valid_q |=> valid_q && $stable(addr_q))
        else $error("latched address changed");
    addr_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_02
        valid_q |-> (addr_q inside {[7'h10:7'h17], [7'h40:7'h47],
                                    [7'h50:7'h5A]}))
        else $error("decoded address out of range");
endmodule

/* sat_target.sv */
// smbus target: address match, timeouts, stretch limit, alert masks
//
// Operation
// RULE_01 - each strap reads as high, low or floating
// RULE_02 - 27 strap combinations map onto fixed addresses, 40h to 5Ah; code maps indices 8 to 15 onto 10h to 17h instead
// RULE_03 - decoded value is the 7-bit address; eighth bit is direction
// RULE_04 - clock held low past the minimum timeout declares a timeout
// RULE_05 - on timeout abandon the transfer before the maximum timeout
// RULE_06 - cumulative stretch per message over limit releases lines, resets
// RULE_07 - host keeps its per-byte clock extension under its limit
// RULE_08 - clock high past the maximum high time means bus idle
// RULE_09 - alert is blocked if either of two masks blocks it
// RULE_10 - one mask is a software mask written at command D8h
// RULE_11 - winning an alert response read sets auto mask for present faults
// RULE_12 - auto mask clears only on a clear faults command
// RULE_13 - acknowledge only our own address; ignore all others; code also acks a read at 0Ch while its alert is asserted
// RULE_14 - straps sampled and address latched before first transfer
module sat_target #(
    parameter int unsigned TIMEOUT_CYC  = sat_pkg::TIMEOUT_CYC,
    parameter int unsigned SEXT_CYC     = sat_pkg::SEXT_CYC,
    parameter int unsigned HIGH_MAX_CYC = sat_pkg::HIGH_MAX_CYC
) (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [1:0] addr_strap_bit0_i,
    input  wire logic [1:0] addr_strap_bit1_i,
    input  wire logic [1:0] addr_strap_bit2_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [7:0] fault_i,
    output logic            smba_o,
    output logic            smba_oe_o,
    output logic            bus_idle_o,
    output logic            timeout_o,
    output logic [6:0]      own_addr_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK
    } sat_state_type;

    sat_addr_if addr_if ();

    sat_strap u_strap (
        .mclk_i            (mclk_i),
        .sys_rst_i         (sys_rst_i),
        .addr_strap_bit0_i (addr_strap_bit0_i),
        .addr_strap_bit1_i (addr_strap_bit1_i),
        .addr_strap_bit2_i (addr_strap_bit2_i),
        .addr_if           (addr_if.source)
    );

    sat_state_type          st_q;
    logic                   scl_q, sda_q;
    logic [3:0]             bit_q;
    logic [7:0]             sh_q, tx_q, cmd_q, mask_q, auto_q;
    logic                   have_cmd_q, rw_q, ara_q, nack_q;
    logic                   sda_oe_q, scl_oe_q, smba_oe_q;
    logic [sat_pkg::CNT_W-1:0] low_q, high_q, sum_q;
    logic [3:0]             str_q;
    logic                   tout_q, idle_q;
    logic [6:0]             own_q;

    logic scl_rise, scl_fall, start, stop, tout_hit, sext_hit, abort;
    logic addr_ok, ara_ok, byte_end;
    logic [7:0] alert_src;

    // bus event decode, straps gate acceptance of starts
    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start    = scl_i && scl_q && sda_q && !sda_i && addr_if.valid; // RULE_14
    assign stop     = scl_i && scl_q && !sda_q && sda_i;
    assign tout_hit = !scl_i && low_q == sat_pkg::CNT_W'(TIMEOUT_CYC);
    assign sext_hit = scl_oe_q && sum_q == sat_pkg::CNT_W'(SEXT_CYC - 1);
    assign abort    = tout_hit || sext_hit;
    assign byte_end = scl_fall && bit_q == 4'h8;
    assign alert_src = fault_i & ~mask_q & ~auto_q; // RULE_09
    assign addr_ok  = sh_q[7:1] == addr_if.addr; // RULE_03
    assign ara_ok   = sh_q[7:1] == sat_pkg::ARA_ADDR && sh_q[0]
                      && smba_oe_q;

    // input history for edge detection
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // clock low timer and timeout pulse
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            low_q  <= '0;
            tout_q <= 1'b0;
        end else begin
            low_q  <= (scl_i || tout_hit) ? '0 : low_q + 1'b1; // RULE_04
            tout_q <= tout_hit;
        end
    end

    // clock high timer for idle detection
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            high_q <= '0;
            idle_q <= 1'b0;
        end else if (!scl_i || start) begin
            high_q <= '0;
            idle_q <= 1'b0;
        end else if (high_q == sat_pkg::CNT_W'(HIGH_MAX_CYC)) begin
            idle_q <= 1'b1; // RULE_08
        end else begin
            high_q <= high_q + 1'b1;
        end
    end

    // cumulative stretch over one message
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || start || stop) begin
            sum_q <= '0;
        end else if (scl_oe_q && !sext_hit) begin
            sum_q <= sum_q + 1'b1; // RULE_06
        end
    end

    // stretch after each byte the target acknowledges, dropped on abort
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || abort || start || stop) begin
            scl_oe_q <= 1'b0; // RULE_06
            str_q    <= '0;
        end else if (st_q == ST_ACK && scl_fall) begin
            scl_oe_q <= 1'b1;
            str_q    <= 4'(sat_pkg::STRETCH_CYC);
        end else if (str_q != '0) begin
            str_q    <= str_q - 1'b1;
            scl_oe_q <= str_q != 4'h1;
        end
    end

    // protocol state machine and data lane
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || abort || stop) begin
            st_q       <= ST_IDLE; // RULE_05
            sda_oe_q   <= 1'b0;
            bit_q      <= '0;
            sh_q       <= '0;
            tx_q       <= '0;
            have_cmd_q <= 1'b0;
            rw_q       <= 1'b0;
            ara_q      <= 1'b0;
            nack_q     <= 1'b0;
        end else if (start) begin
            st_q     <= ST_ADDR;
            sda_oe_q <= 1'b0;
            bit_q    <= '0;
            ara_q    <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: ;
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_i};
                        bit_q <= bit_q + 1'b1;
                    end else if (byte_end) begin
                        bit_q <= '0;
                        if (st_q == ST_RX) begin
                            have_cmd_q <= 1'b1;
                            st_q       <= ST_ACK;
                            sda_oe_q   <= 1'b1;
                        end else if (addr_ok || ara_ok) begin
                            rw_q     <= sh_q[0];
                            ara_q    <= ara_ok;
                            st_q     <= ST_ACK;
                            sda_oe_q <= 1'b1; // RULE_13
                        end else begin
                            st_q <= ST_IDLE; // RULE_13
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            tx_q     <= ara_q ? {own_q, 1'b0} : (
                                        cmd_q == sat_pkg::CMD_ALERT_MASK
                                        ? mask_q : fault_i);
                            st_q     <= ST_TX;
                            sda_oe_q <= 1'b0;
                            bit_q    <= '0;
                        end else begin
                            st_q     <= ST_RX;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise && ara_q && sda_i == sda_oe_q) begin
                        st_q     <= ST_IDLE; // lost arbitration
                        sda_oe_q <= 1'b0;
                    end else if (byte_end) begin
                        sda_oe_q <= 1'b0;
                        st_q     <= ST_MACK;
                        ara_q    <= 1'b0;
                    end else if (scl_fall || (bit_q == '0 && !scl_i)) begin
                        sda_oe_q <= !tx_q[7];
                        tx_q     <= {tx_q[6:0], 1'b0};
                        bit_q    <= bit_q + 1'b1;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_i;
                    end else if (scl_fall) begin
                        st_q  <= nack_q ? ST_IDLE : ST_TX;
                        bit_q <= '0;
                        tx_q  <= fault_i;
                    end
                end
            endcase
        end
    end

    // command byte, software mask and automatic mask
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cmd_q  <= '0;
            mask_q <= sat_pkg::ALERT_MASK_RST;
            auto_q <= '0;
        end else if (st_q == ST_RX && byte_end && !abort && !stop) begin
            if (!have_cmd_q) begin
                cmd_q <= sh_q;
                if (sh_q == sat_pkg::CMD_CLEAR_FAULTS) begin
                    auto_q <= '0; // RULE_12
                end
            end else if (cmd_q == sat_pkg::CMD_ALERT_MASK) begin
                mask_q <= sh_q; // RULE_10
            end
        end else if (st_q == ST_TX && ara_q && byte_end && !abort && !stop) begin
            auto_q <= auto_q | fault_i; // RULE_11
        end
    end

    // registered outputs
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            smba_oe_q <= 1'b0;
            own_q     <= '0;
        end else begin
            smba_oe_q <= |alert_src; // RULE_09
            own_q     <= addr_if.addr;
        end
    end

    assign scl_o      = 1'b0;
    assign sda_o      = 1'b0;
    assign smba_o     = 1'b0;
    assign scl_oe_o   = scl_oe_q;
    assign sda_oe_o   = sda_oe_q;
    assign smba_oe_o  = smba_oe_q;
    assign bus_idle_o = idle_q;
    assign timeout_o  = tout_q;
    assign own_addr_o = own_q;

    timeout_reset_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_05
        tout_q |-> st_q == ST_IDLE && !sda_oe_q && !scl_oe_q)
        else $error("timeout did not reset the interface");
    stretch_limit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_06
        sum_q < sat_pkg::CNT_W'(SEXT_CYC))
        else $error("cumulative stretch over limit");
    addr_ignore_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_13
        st_q == ST_ADDR && byte_end && !addr_ok && !ara_ok && !abort && !stop
        |=> st_q == ST_IDLE && !sda_oe_q)
        else $error("foreign address touched the bus");
    addr_ack_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_03
        st_q == ST_ADDR && byte_end && addr_ok && !abort && !stop
        |=> sda_oe_q && rw_q == $past(sh_q[0]))
        else $error("own address not acknowledged");
    mask_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_09
        (fault_i & ~mask_q) == '0 ##1 $stable(mask_q) |-> !smba_oe_q)
        else $error("masked fault drove alert");
    clear_auto_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_12
        st_q == ST_RX && byte_end && !have_cmd_q && !abort && !stop
        && sh_q == sat_pkg::CMD_CLEAR_FAULTS |=> auto_q == '0)
        else $error("auto mask not cleared");
    ara_win_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_11
        st_q == ST_TX && ara_q && byte_end && !abort && !stop
        |=> (auto_q & $past(fault_i)) == $past(fault_i))
        else $error("auto mask missed a fault");
    idle_high_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_08
        idle_q |-> scl_q && high_q == sat_pkg::CNT_W'(HIGH_MAX_CYC))
        else $error("idle without clock high time");
    no_early_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RULE_14
        !addr_if.valid |-> st_q == ST_IDLE)
        else $error("transfer before address latched");
endmodule

/* sat_host_model.sv */
// smbus host controller model driving open-drain clock and data lines
module sat_host_model #(
    parameter int HALF = 10
) (
    input  wire logic mclk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // both lines released at power up
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // wait whole clock cycles, driving on the falling edge
    task automatic hw(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // release clock, follow target stretch with a bound
    task automatic rise();
        int k;
        scl_oe_o = 1'b0;
        k = 0;
        while (!scl_i && k < 100) begin
            @(negedge mclk_i);
            k++;
        end
        hw(HALF);
    endtask
    // start or repeated start; low phase kept short
    task automatic start();
        sda_oe_o = 1'b0;
        hw(1);
        rise();
        sda_oe_o = 1'b1;
        hw(HALF);
        scl_oe_o = 1'b1;
        hw(1);
    endtask
    // one bit: data set one cycle after clock fall
    task automatic bit_x(input logic b, output logic s);
        sda_oe_o = ~b;
        hw(HALF);
        rise();
        s = sda_i;
        scl_oe_o = 1'b1;
        hw(1);
    endtask
    // byte out msb first, ack read back
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    // byte in msb first, then ack or nack
    task automatic rd_byte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(nack, s);
    endtask
    // stop condition
    task automatic stop();
        sda_oe_o = 1'b1;
        hw(HALF);
        rise();
        sda_oe_o = 1'b0;
        hw(HALF);
    endtask
    // abandon after a timeout: free both lines
    task automatic free();
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        hw(HALF);
    endtask
endmodule

/* test_smbus_target_addr_timeout.sv */
// testbench for the smbus target address and timeout block
module test_smbus_target_addr_timeout;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO_C = 200;
    localparam int SX_C = 60;
    localparam int HI_C = 40;
    localparam int HALF = 10;
    logic       mclk_i;
    logic       sys_rst_i;
    logic [1:0] st0, st1, st2;
    logic [7:0] fault;
    logic       scl_oe, sda_oe, smba_oe, idle, tmo;
    logic       h_scl, h_sda, scl, sda, a;
    logic       sda_watch, sda_seen;
    logic       od_scl, od_sda, od_smba;
    logic [6:0] own, me;
    logic [7:0] d;
    int         n;
    int         mismatches;
    int         checks_done;
    // open-drain wires with pull-ups
    assign scl = ~(h_scl | scl_oe);
    assign sda = ~(h_sda | sda_oe);
    sat_target #(.TIMEOUT_CYC(TO_C), .SEXT_CYC(SX_C), .HIGH_MAX_CYC(HI_C))
    i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .addr_strap_bit0_i(st0), .addr_strap_bit1_i(st1),
        .addr_strap_bit2_i(st2), .scl_i(scl), .scl_o(od_scl),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(od_sda),
        .sda_oe_o(sda_oe), .fault_i(fault), .smba_o(od_smba),
        .smba_oe_o(smba_oe), .bus_idle_o(idle),
        .timeout_o(tmo), .own_addr_o(own));
    sat_host_model #(.HALF(HALF)) i_host (.mclk_i(mclk_i), .scl_i(scl),
        .sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));
    // clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // sticky record of any target pull on either line
    always @(posedge mclk_i) begin
        sda_seen <= sda_watch & (sda_seen | sda_oe | scl_oe);
    end
    // comparisons
    task automatic chk_flag(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: value %h expected %h", $time, g, e);
        end
    endtask
    // expected address of a strap index (digits float, low, high)
    function automatic logic [6:0] exp_addr(input int i);
        if (i < 8) return 7'h40 + 7'(i);
        if (i < 16) return 7'h10 + 7'(i - 8);
        return 7'h50 + 7'(i - 16);
    endfunction
    function automatic logic [1:0] code(input int dg);
        return (dg == 0) ? 2'h0 : ((dg == 1) ? 2'h1 : 2'h2);
    endfunction
    task automatic do_reset(input int i);
        st0 = code(i % 3);
        st1 = code((i / 3) % 3);
        st2 = code(i / 9);
        sys_rst_i = 1'b1;
        repeat (12) @(negedge mclk_i);
        sys_rst_i = 1'b0;
    endtask
    // write an address byte plus command and optional data
    task automatic wr_msg(input logic [7:0] c, input logic [7:0] v,
                          input logic has_v);
        i_host.start();
        i_host.wr_byte({me, 1'b0}, a);
        i_host.wr_byte(c, a);
        if (has_v) begin
            i_host.wr_byte(v, a);
        end
        i_host.stop();
    endtask
    task automatic rd_msg(input logic [6:0] ad, output logic [7:0] q);
        i_host.start();
        i_host.wr_byte({ad, 1'b1}, a);
        i_host.rd_byte(q, 1'b1);
        i_host.stop();
    endtask
    // every strap combination decodes, latched only after settle
    task automatic t_decode();
        for (int i = 0; i < 27; i++) begin
            do_reset(i);
            repeat (5) @(negedge mclk_i);
            chk_val({1'b0, own}, 8'h00);
            repeat (15) @(negedge mclk_i);
            chk_val({1'b0, own}, {1'b0, exp_addr(i)});
        end
        me = exp_addr(13);
        do_reset(13);
        repeat (20) @(negedge mclk_i);
    endtask
    // own address acked, foreign ignored, read bit honoured
    task automatic t_match();
        i_host.start();
        i_host.wr_byte({me, 1'b0}, a);
        chk_flag(a, 1'b1);
        i_host.stop();
        sda_watch = 1'b1;
        i_host.start();
        i_host.wr_byte({me + 7'h01, 1'b0}, a);
        i_host.wr_byte(8'h00, a);
        i_host.stop();
        chk_flag(sda_seen, 1'b0);
        sda_watch = 1'b0;
        fault = 8'h21;
        // two byte read: host ack continues, nack ends
        i_host.start();
        i_host.wr_byte({me, 1'b1}, a);
        i_host.rd_byte(d, 1'b0);
        chk_val(d, 8'h21);
        i_host.rd_byte(d, 1'b1);
        chk_val(d, 8'h21);
        i_host.stop();
    endtask
    // software mask gates the alert
    task automatic t_mask();
        fault = 8'h0F;
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b1);
        chk_flag(od_scl | od_sda | od_smba, 1'b0);
        wr_msg(8'hD8, 8'h0F, 1'b1);
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b0);
        rd_msg(me, d);
        chk_val(d, 8'h0F);
        fault = 8'h3F;
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b1);
        wr_msg(8'hD8, 8'h00, 1'b1);
    endtask
    // alert response read sets the auto mask, clear faults frees it
    task automatic t_ara();
        fault = 8'h30;
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b1);
        // host drives zeros: target loses at its first one bit
        i_host.start();
        i_host.wr_byte({7'h0C, 1'b1}, a);
        i_host.wr_byte(8'h00, a);
        chk_flag(a, 1'b0);
        i_host.stop();
        chk_flag(smba_oe, 1'b1);
        rd_msg(7'h0C, d);
        chk_val(d, {me, 1'b0});
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b0);
        wr_msg(8'h03, 8'h00, 1'b0);
        repeat (3) @(negedge mclk_i);
        chk_flag(smba_oe, 1'b1);
        fault = 8'h00;
    endtask
    // clock held low mid-message until the target gives up
    task automatic t_timeout();
        i_host.start();
        i_host.wr_byte({me, 1'b0}, a);
        n = 0;
        while (tmo !== 1'b1 && n < 400) begin
            @(negedge mclk_i);
            n++;
        end
        chk_flag(n >= TO_C - 5 && n <= TO_C + 5, 1'b1);
        chk_flag(sda_oe | scl_oe, 1'b0);
        i_host.free();
        i_host.start();
        i_host.wr_byte({me, 1'b0}, a);
        chk_flag(a, 1'b1);
        i_host.stop();
    endtask
    // idle flag rises after the high limit, falls on start
    task automatic t_idle();
        i_host.start();
        i_host.stop();
        n = 0;
        while (idle !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        chk_flag(n >= HI_C - 2 * HALF - 5 && n <= HI_C - 2 * HALF + 5,
                 1'b1);
        i_host.start();
        chk_flag(idle, 1'b0);
        i_host.stop();
    endtask
    // long message: stretch sum reaches limit and target lets go
    task automatic t_stretch();
        i_host.start();
        i_host.wr_byte({me, 1'b0}, a);
        for (int i = 1; i <= 8; i++) begin
            i_host.wr_byte(8'h77, a);
            chk_flag(a, 1'(sat_pkg::STRETCH_CYC * i < SX_C));
        end
        chk_flag(sda_oe | scl_oe, 1'b0);
        i_host.stop();
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge mclk_i);
        mismatches++;
        print_verdict();
    end
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        st0 = 2'h0;
        st1 = 2'h0;
        st2 = 2'h0;
        fault = 8'h00;
        sda_watch = 1'b0;
        mismatches = 0;
        checks_done = 0;
        t_decode();
        t_match();
        t_mask();
        t_ara();
        t_timeout();
        t_idle();
        t_stretch();
        print_verdict();
    end
endmodule
